// [hdl/ppn_debounce.sv]
`timescale 1ns/1ps
module ppn_debounce
    import ppn_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    input  wire logic i_key,
    output logic      o_press
);
    logic [20:0] cnt_reg;
    logic        stable_reg;
    logic        press_reg;
    wire         differ = (i_key != stable_reg);
    wire         settle = differ && (cnt_reg == 21'(DEBOUNCE_CYC - 1));

    // the level must hold for the whole window before it is accepted,
    // so a long press still yields one event on its rising edge
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            cnt_reg    <= 21'h0;
            stable_reg <= 1'b0;
            press_reg  <= 1'b0;
        end else begin
            cnt_reg    <= (differ && !settle) ? cnt_reg + 21'h1 : 21'h0;
            stable_reg <= settle ? i_key : stable_reg;
            press_reg  <= settle && i_key;
        end
    end
    assign o_press = press_reg;

    property p_one_event;
        @(posedge i_clock) disable iff (!i_reset_n)
        press_reg |=> !press_reg;
    endproperty
    a_one_event: assert property (p_one_event) else $error("press pulse too long");
endmodule

// [hdl/ppn_panel.sv]
`timescale 1ns/1ps
module ppn_panel
    import ppn_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic [4:0]  i_keys,
    input  wire logic [3:0]  i_monitor_selection_method_setting,
    input  wire logic        i_running,
    input  wire logic        i_stop_only,
    input  wire logic [3:0]  i_sub_max,
    input  wire logic [19:0] i_param_value,
    input  wire logic [3:0]  i_seq_in,
    input  wire logic [3:0]  i_seq_out,
    input  wire logic [7:0]  i_seq_target,
    output logic [2:0]       o_mode,
    output logic [6:0]       o_main_no,
    output logic [3:0]       o_sub_no,
    output logic [19:0]      o_digits,
    output logic [4:0]       o_dp,
    output logic [4:0]       o_digit_blank,
    output logic [7:0]       o_seq_segments,
    output logic             o_show_value,
    output logic             o_run_shown,
    output logic             o_ext_monitor,
    output logic             o_commit,
    output logic [19:0]      o_commit_value
);
    // ************************************************************
    // key conditioning
    // ************************************************************
    wire [4:0] press;
    genvar k;
    generate
        for (k = 0; k < NUM_KEYS; k++) begin : g_key
            ppn_debounce u_deb (
                .i_clock   (i_clock),
                .i_reset_n (i_reset_n),
                .i_key     (i_keys[k]),
                .o_press   (press[k])
            );
        end
    endgenerate

    wire [7:0] seq_seg;
    wire       seq_dp;
    ppn_seq_display u_seq (
        .i_clock      (i_clock),
        .i_reset_n    (i_reset_n),
        .i_seq_in     (i_seq_in),
        .i_seq_out    (i_seq_out),
        .i_seq_target (i_seq_target),
        .o_segments   (seq_seg),
        .o_dp         (seq_dp)
    );

    // ************************************************************
    // state
    // ************************************************************
    ppn_mode_e   mode_reg, mode_next;
    ppn_nav_e    nav_reg, nav_next;
    logic [6:0]  main_reg;
    logic [3:0]  sub_reg;
    logic [19:0] edit_reg;
    logic [2:0]  pos_reg;
    logic [27:0] timer_reg;
    logic        show_value_reg;
    logic        alt_reg;
    logic        blink_reg;
    logic        run_reg;
    logic        commit_reg;

    wire main_sub   = (i_monitor_selection_method_setting == SEL_METHOD_MAIN_SUB);
    wire k_mode     = press[KEY_MODE];
    wire k_set      = press[KEY_SET];
    wire k_up       = press[KEY_UP];
    wire k_down     = press[KEY_DOWN];
    wire k_shift    = press[KEY_SHIFT];
    wire is_monitor = (mode_reg == PPN_MODE_MON);
    wire is_ext     = is_monitor && (main_reg == EXT_MON_MAIN) && (sub_reg <= EXT_MON_SUB_LAST);
    wire is_seq     = is_monitor && (main_reg == SEQ_IO_MAIN) && (nav_reg == PPN_NAV_SHOW);
    wire selecting  = (nav_reg == PPN_NAV_MAIN) || (nav_reg == PPN_NAV_SUB);
    wire refuse     = i_stop_only && i_running;
    wire num_due    = (timer_reg == 28'(NUM_SWITCH_CYC - 1));
    wire alt_due    = (timer_reg == 28'(ALT_HALF_CYC - 1));
    wire [3:0] dig_sel = edit_reg[pos_reg*4 +: 4];

    always_comb begin
        case (mode_reg)
            PPN_MODE_MON:   mode_next = PPN_MODE_BLK_A;
            PPN_MODE_BLK_A: mode_next = PPN_MODE_BLK_B;
            PPN_MODE_BLK_B: mode_next = PPN_MODE_BLK_C;
            PPN_MODE_BLK_C: mode_next = PPN_MODE_UTIL;
            default:        mode_next = PPN_MODE_MON;
        endcase
    end

    // navigation; the mode key always restarts selection at the main number
    always_comb begin
        nav_next = nav_reg;
        case (nav_reg)
            PPN_NAV_MAIN: begin
                if (k_shift && main_sub) begin
                    nav_next = PPN_NAV_SUB;
                end else if (k_set) begin
                    nav_next = PPN_NAV_SHOW;
                end
            end
            PPN_NAV_SUB: begin
                if (k_shift) begin
                    nav_next = PPN_NAV_MAIN;
                end else if (k_set) begin
                    nav_next = PPN_NAV_SHOW;
                end
            end
            PPN_NAV_SHOW: begin
                if (k_set && !is_monitor && !refuse) begin
                    nav_next = PPN_NAV_EDIT;
                end else if (k_set && is_ext) begin
                    nav_next = PPN_NAV_EXT;
                end else if (k_shift || (k_set && is_monitor)) begin
                    nav_next = PPN_NAV_MAIN;
                end
            end
            PPN_NAV_EDIT: begin
                if (k_set) begin
                    nav_next = PPN_NAV_SHOW;
                end
            end
            PPN_NAV_EXT: begin
                if (k_set) begin
                    nav_next = PPN_NAV_SHOW;
                end
            end
            default: nav_next = PPN_NAV_MAIN;
        endcase
        if (k_mode) begin
            nav_next = PPN_NAV_MAIN;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            mode_reg <= PPN_MODE_MON;
            nav_reg  <= PPN_NAV_MAIN;
        end else begin
            mode_reg <= k_mode ? mode_next : mode_reg;
            nav_reg  <= nav_next;
        end
    end

    wire [3:0] sub_up   = (sub_reg >= i_sub_max) ? 4'h0 : sub_reg + 4'h1;
    wire [3:0] sub_down = (sub_reg == 4'h0) ? i_sub_max : sub_reg - 4'h1;
    wire [6:0] main_up  = (main_reg == MAIN_MAX) ? 7'h00 : main_reg + 7'h01;
    wire [6:0] main_dn  = (main_reg == 7'h00) ? MAIN_MAX : main_reg - 7'h01;
    wire in_sub = (nav_reg == PPN_NAV_SUB) && main_sub;
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || k_mode) begin
            main_reg <= 7'h00;
            sub_reg  <= 4'h0;
        end else if (in_sub) begin
            sub_reg <= k_up ? sub_up : (k_down ? sub_down : sub_reg);
        end else if (nav_reg == PPN_NAV_MAIN) begin
            main_reg <= k_up ? main_up : (k_down ? main_dn : main_reg);
            sub_reg  <= (k_up || k_down) ? 4'h0 : sub_reg;
        end
    end

    wire [3:0] dig_up = (dig_sel == 4'h9) ? 4'h0 : dig_sel + 4'h1;
    wire [3:0] dig_dn = (dig_sel == 4'h0) ? 4'h9 : dig_sel - 4'h1;
    wire [2:0] pos_nx = (pos_reg == 3'(NUM_DIGITS - 1)) ? 3'h0 : pos_reg + 3'h1;
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            edit_reg <= 20'h0;
            pos_reg  <= 3'h0;
        end else if (nav_reg != PPN_NAV_EDIT) begin
            edit_reg <= i_param_value;
            pos_reg  <= 3'h0;
        end else begin
            if (k_up) begin
                edit_reg[pos_reg*4 +: 4] <= dig_up;
            end else if (k_down) begin
                edit_reg[pos_reg*4 +: 4] <= dig_dn;
            end
            pos_reg <= k_shift ? pos_nx : pos_reg;
        end
    end

    // shared timer: one second switch on monitors, half second alternation on block parameters
    wire timer_clr = (nav_next != nav_reg) || k_up || k_down || num_due
                   || (!is_monitor && alt_due);
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || timer_clr) begin
            timer_reg <= 28'h0;
        end else begin
            timer_reg <= timer_reg + 28'h1;
        end
    end

    // block parameters alternate number and value
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || (nav_next != nav_reg)) begin
            show_value_reg <= 1'b0;
            alt_reg        <= 1'b0;
        end else if (nav_reg == PPN_NAV_SHOW && !is_monitor && alt_due) begin
            alt_reg        <= !alt_reg;
            show_value_reg <= !alt_reg;
        end else if (nav_reg != PPN_NAV_SHOW && is_monitor && selecting && num_due) begin
            show_value_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n || k_mode || k_shift) begin
            run_reg <= 1'b0;
        end else if (nav_reg == PPN_NAV_SHOW && k_set && !is_monitor && refuse) begin
            run_reg <= 1'b1;
        end
    end

    // flashing digit and commit strobe
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            blink_reg  <= 1'b0;
            commit_reg <= 1'b0;
        end else begin
            blink_reg  <= (timer_reg == 28'(EDIT_BLINK_CYC)) ? !blink_reg : blink_reg;
            commit_reg <= (nav_reg == PPN_NAV_EDIT) && k_set;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic [19:0] digits_reg;
    logic [4:0]  dp_reg;
    logic [4:0]  blank_reg;
    logic [7:0]  seg_out_reg;
    logic [19:0] commit_val_reg;
    wire [4:0] dp_sel  = (main_sub && selecting) ? 5'(1 << DP_MAIN_SUB) : 5'h00;
    wire [4:0] dp_nx   = is_seq ? {4'h0, seq_dp} : dp_sel;
    wire [19:0] num_dg = {4'h0, 1'b0, main_reg, 4'h0, sub_reg};
    wire [19:0] dig_nx = (nav_reg == PPN_NAV_EDIT) ? edit_reg
                       : (show_value_reg ? i_param_value : num_dg);
    wire [4:0] blk_nx  = (nav_reg == PPN_NAV_EDIT && blink_reg) ? 5'(1 << pos_reg) : 5'h00;
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            digits_reg     <= 20'h0;
            dp_reg         <= 5'h00;
            blank_reg      <= 5'h00;
            seg_out_reg    <= 8'h00;
            commit_val_reg <= 20'h0;
        end else begin
            digits_reg     <= dig_nx;
            dp_reg         <= dp_nx;
            blank_reg      <= blk_nx;
            seg_out_reg    <= is_seq ? seq_seg : 8'h00;
            commit_val_reg <= ((nav_reg == PPN_NAV_EDIT) && k_set) ? edit_reg : commit_val_reg;
        end
    end

    logic ext_reg;
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            ext_reg <= 1'b0;
        end else begin
            ext_reg <= (nav_reg == PPN_NAV_EXT);
        end
    end

    assign o_mode         = mode_reg;
    assign o_main_no      = main_reg;
    assign o_sub_no       = sub_reg;
    assign o_digits       = digits_reg;
    assign o_dp           = dp_reg;
    assign o_digit_blank  = blank_reg;
    assign o_seq_segments = seg_out_reg;
    assign o_show_value   = show_value_reg;
    assign o_run_shown    = run_reg;
    assign o_ext_monitor  = ext_reg;
    assign o_commit       = commit_reg;
    assign o_commit_value = commit_val_reg;

    // ************************************************************
    // checks
    // ************************************************************
    property p_mode_step;
        @(posedge i_clock) disable iff (!i_reset_n)
        (k_mode && mode_reg == PPN_MODE_UTIL) |=> (mode_reg == PPN_MODE_MON);
    endproperty
    a_mode_step: assert property (p_mode_step) else $error("mode cycle did not wrap");
    property p_sub_wrap;
        @(posedge i_clock) disable iff (!i_reset_n)
        (in_sub && k_up && !k_mode && sub_reg >= i_sub_max)
            |=> (sub_reg == 4'h0 && $stable(main_reg));
    endproperty
    a_sub_wrap: assert property (p_sub_wrap) else $error("sub number did not wrap");
    property p_no_sub;
        @(posedge i_clock) disable iff (!i_reset_n)
        (!main_sub && nav_reg != PPN_NAV_SUB) |=> (nav_reg != PPN_NAV_SUB);
    endproperty
    a_no_sub: assert property (p_no_sub) else $error("sub selection without method 2");
    property p_dp3;
        @(posedge i_clock) disable iff (!i_reset_n)
        (main_sub && selecting && !is_seq) |=> dp_reg[DP_MAIN_SUB];
    endproperty
    a_dp3: assert property (p_dp3) else $error("third point dark while selecting");
    property p_refuse;
        @(posedge i_clock) disable iff (!i_reset_n)
        (nav_reg == PPN_NAV_SHOW && k_set && !k_mode && !is_monitor && refuse)
            |=> (nav_reg != PPN_NAV_EDIT) && run_reg;
    endproperty
    a_refuse: assert property (p_refuse) else $error("stop-only edit accepted");
    property p_enter_edit;
        @(posedge i_clock) disable iff (!i_reset_n)
        (nav_reg == PPN_NAV_SHOW && k_set && !k_mode && !is_monitor && !refuse)
            |=> (nav_reg == PPN_NAV_EDIT);
    endproperty
    a_enter_edit: assert property (p_enter_edit) else $error("set missed editing");
    property p_commit;
        @(posedge i_clock) disable iff (!i_reset_n)
        (nav_reg == PPN_NAV_EDIT && k_set) |=> (o_commit && o_commit_value == $past(edit_reg));
    endproperty
    a_commit: assert property (p_commit) else $error("commit value wrong");
    property p_mon_num;
        @(posedge i_clock) disable iff (!i_reset_n)
        (is_monitor && nav_reg == PPN_NAV_SHOW && k_set && !k_mode && !is_ext)
            |=> (nav_reg == PPN_NAV_MAIN && !show_value_reg);
    endproperty
    a_mon_num: assert property (p_mon_num) else $error("set did not show number");
endmodule

// [hdl/ppn_pkg.sv]
package ppn_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned NUM_SWITCH_MS    = 1000;   // number to value delay
    localparam int unsigned NUM_SWITCH_CYC   = NUM_SWITCH_MS * 100_000 / CLK_PERIOD_NS * 10;
    localparam int unsigned DP_FLASH_MS      = 1000;   // full flash period
    localparam int unsigned DP_HALF_CYC      = DP_FLASH_MS * 1_000_000 / CLK_PERIOD_NS / 2;
    localparam int unsigned ALT_HALF_MS      = 500;    // number/value alternation half period
    localparam int unsigned ALT_HALF_CYC     = ALT_HALF_MS * 1_000_000 / CLK_PERIOD_NS;
    // keys arrive from a scanned pad; a short window rejects single glitches and
    // keeps a press cheap, a raw contact pad would need this count raised
    localparam int unsigned DEBOUNCE_CYC     = 32;
    localparam int unsigned EDIT_BLINK_CYC   = ALT_HALF_CYC / 2;

    // ************************************************************
    // settings, keys, groups
    // ************************************************************
    localparam logic [3:0] SEL_METHOD_MAIN_SUB = 4'h2;
    localparam int         NUM_KEYS            = 5;
    localparam int         KEY_MODE            = 0;
    localparam int         KEY_SET             = 1;
    localparam int         KEY_UP              = 2;
    localparam int         KEY_DOWN            = 3;
    localparam int         KEY_SHIFT           = 4;
    localparam logic [6:0] MAIN_MAX            = 7'h63;
    localparam logic [6:0] EXT_MON_MAIN        = 7'h14;  // extended monitor entry group
    localparam logic [6:0] SEQ_IO_MAIN         = 7'h04;  // sequence io monitor group
    localparam logic [3:0] EXT_MON_SUB_LAST    = 4'h2;
    localparam int         NUM_DIGITS          = 5;
    localparam int         DP_MAIN_SUB         = 2;      // third decimal point
    localparam int         DP_SEQ              = 0;
    localparam logic [7:0] RESET_VALUE         = 8'h00;

    // panel modes, Gray-coded from MON to UTIL along the key cycle
    typedef enum logic [2:0] {
        PPN_MODE_MON   = 3'b000,
        PPN_MODE_BLK_A = 3'b001,
        PPN_MODE_BLK_B = 3'b011,
        PPN_MODE_BLK_C = 3'b010,
        PPN_MODE_UTIL  = 3'b110
    } ppn_mode_e;

    // navigation states, Gray-coded along the usual path
    typedef enum logic [2:0] {
        PPN_NAV_MAIN  = 3'b000,
        PPN_NAV_SUB   = 3'b001,
        PPN_NAV_SHOW  = 3'b011,
        PPN_NAV_EDIT  = 3'b010,
        PPN_NAV_EXT   = 3'b110
    } ppn_nav_e;
endpackage

// [hdl/ppn_seq_display.sv]
`timescale 1ns/1ps
module ppn_seq_display
    import ppn_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,
    input  wire logic [3:0] i_seq_in,
    input  wire logic [3:0] i_seq_out,
    input  wire logic [7:0] i_seq_target,
    output logic [7:0]      o_segments,
    output logic            o_dp
);
    logic [7:0]  seg_reg;
    logic [25:0] dp_cnt_reg;
    logic        dp_reg;
    wire  [7:0]  seq_all = {i_seq_out, i_seq_in};
    wire  [7:0]  seg_next;

    // inputs at 0..3, outputs at 4..7
    // lit only when on and a target
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_seg
            assign seg_next[g] = seq_all[g] & i_seq_target[g];
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            seg_reg <= 8'h00;
        end else begin
            seg_reg <= seg_next;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            dp_cnt_reg <= 26'h0;
            dp_reg     <= 1'b0;
        end else if (dp_cnt_reg == 26'(DP_HALF_CYC - 1)) begin
            dp_cnt_reg <= 26'h0;
            dp_reg     <= !dp_reg;
        end else begin
            dp_cnt_reg <= dp_cnt_reg + 26'h1;
        end
    end
    assign o_segments = seg_reg;
    assign o_dp       = dp_reg;

    property p_seg_follow;
        @(posedge i_clock) disable iff (!i_reset_n)
        1'b1 |=> (seg_reg == ($past({i_seq_out, i_seq_in}) & $past(i_seq_target)));
    endproperty
    a_seg_follow: assert property (p_seg_follow) else $error("segment lagged");
    property p_seg_dark;
        @(posedge i_clock) disable iff (!i_reset_n)
        (i_seq_in[0] == 1'b0) |=> (seg_reg[0] == 1'b0);
    endproperty
    a_seg_dark: assert property (p_seg_dark) else $error("segment lit while off");
    property p_dp_flash;
        @(posedge i_clock) disable iff (!i_reset_n)
        (dp_cnt_reg != 26'(DP_HALF_CYC - 1)) |=> $stable(dp_reg);
    endproperty
    a_dp_flash: assert property (p_dp_flash) else $error("decimal point toggled early");
endmodule

// [verification/ppn_operator.sv]
`timescale 1ns/1ps
// ************************************************************
// keypad operator
// ************************************************************
module ppn_operator
    import ppn_pkg::*;
(
    input  wire logic i_clock,
    output logic [4:0] o_keys
);
    // one key at a time, held and released well past the debounce window
    // one clean press
    task automatic press(input int idx);
        @(negedge i_clock);
        o_keys[idx] = 1'b1;
        repeat (DEBOUNCE_CYC + 16) @(negedge i_clock);
        o_keys[idx] = 1'b0;
        repeat (DEBOUNCE_CYC + 16) @(negedge i_clock);
    endtask

    initial o_keys = 5'h00;
endmodule

// [verification/test_panel_parameter_navigator.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module test_panel_parameter_navigator;
    import ppn_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [4:0]  keys;
    logic [3:0]  sub_max = 4'h1;
    logic [19:0] pval = 20'h00000;
    logic [3:0]  sin = 4'h0, sout = 4'h0;
    logic [7:0]  tgt = 8'h00;
    logic [2:0]  mode;
    logic [6:0]  main_no;
    logic [3:0]  sub_no;
    logic [4:0]  dp;
    logic [7:0]  segs;
    logic [3:0]  msel = SEL_METHOD_MAIN_SUB;
    logic        running = 1'b0, stop_only = 1'b0;
    logic [19:0] digits, cval, exp_val;
    logic [4:0]  blank;
    logic        showv, runs, ext, commit;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0, mi = 0, main = 0, sub = 0;
    int          n_commit = 0;
    ppn_mode_e   cyc [5] = '{PPN_MODE_MON, PPN_MODE_BLK_A, PPN_MODE_BLK_B,
                            PPN_MODE_BLK_C, PPN_MODE_UTIL};

    always #5 i_clock = ~i_clock;

    ppn_operator u_ppn_operator (.i_clock(i_clock), .o_keys(keys));

    ppn_panel u_ppn_panel (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_keys(keys),
        .i_monitor_selection_method_setting(msel),
        .i_running(running), .i_stop_only(stop_only), .i_sub_max(sub_max),
        .i_param_value(pval), .i_seq_in(sin), .i_seq_out(sout), .i_seq_target(tgt),
        .o_mode(mode), .o_main_no(main_no), .o_sub_no(sub_no), .o_digits(digits),
        .o_dp(dp), .o_digit_blank(blank), .o_seq_segments(segs), .o_show_value(showv),
        .o_run_shown(runs), .o_ext_monitor(ext), .o_commit(commit), .o_commit_value(cval));

    task automatic finish_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // the commit strobe stands one cycle, so count it where it is settled
    always @(negedge i_clock) n_commit += int'(commit);

    // about fifty presses of three debounce windows each stay far below this
    always @(posedge i_clock) begin
        cycles++;
        if (cycles >= 20_000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'h2d2c));
        repeat (6) @(negedge i_clock);
        i_reset_n = 1'b1;
        // present value in BCD, the digit editor only counts 0 to 9
        for (int d = 0; d < NUM_DIGITS; d++) begin
            pval[d*4 +: 4] = 4'($urandom % 10);
        end
        @(negedge i_clock);
        `CHK("mode", 3'(cyc[0]), mode)
        `CHK("main", 7'h00, main_no)
        // a full lap of the mode key
        for (int k = 0; k < 5; k++) begin
            u_ppn_operator.press(KEY_MODE);
            mi = (mi + 1) % 5;
            `CHK("mode", 3'(cyc[mi]), mode)
        end
        // step the main number up to the sequence monitor group
        for (int k = 0; k < 4; k++) begin
            u_ppn_operator.press(KEY_UP);
            main = (main + 1) % 100;
            `CHK("main", 7'(main), main_no)
            `CHK("dp_sel", 1'b1, dp[DP_MAIN_SUB])
        end
        // the sequence view only shows once the group is chosen
        u_ppn_operator.press(KEY_SET);
        for (int k = 0; k < 12; k++) begin
            sin = 4'($urandom);
            sout = 4'($urandom);
            tgt = (k == 0) ? 8'hFF : 8'($urandom);
            repeat (3) @(negedge i_clock);
            `CHK("segs", {sout, sin} & tgt, segs)
            `CHK("segs_idx", sout[0] & tgt[4], segs[4])
        end
        // set on a shown monitor brings the parameter number back
        u_ppn_operator.press(KEY_SET);
        `CHK("show", 1'b0, showv)
        `CHK("digits", {5'h00, 7'(main), 4'h0, 4'(sub)}, digits)
        // sub selection wraps inside the same main number
        u_ppn_operator.press(KEY_SHIFT);
        `CHK("sub", 4'h0, sub_no)
        for (int k = 0; k < 2; k++) begin
            u_ppn_operator.press(KEY_UP);
            sub = (sub == int'(sub_max)) ? 0 : sub + 1;
            `CHK("sub", 4'(sub), sub_no)
            `CHK("main", 7'(main), main_no)
        end
        // back to main selection and on to the extended monitor entry group
        u_ppn_operator.press(KEY_SHIFT);
        for (int k = 0; k < 16; k++) begin
            u_ppn_operator.press(KEY_UP);
            main = (main + 1) % 100;
        end
        sub = 0;
        `CHK("main", 7'(main), main_no)
        `CHK("sub", 4'(sub), sub_no)
        u_ppn_operator.press(KEY_SET);
        u_ppn_operator.press(KEY_SET);
        `CHK("ext", 1'b1, ext)
        u_ppn_operator.press(KEY_SET);
        `CHK("ext", 1'b0, ext)
        // block A: a stop-only parameter is refused while running, then edited
        u_ppn_operator.press(KEY_MODE);
        main = 0;
        u_ppn_operator.press(KEY_SET);
        running = 1'b1;
        stop_only = 1'b1;
        u_ppn_operator.press(KEY_SET);
        `CHK("run", 1'b1, runs)
        `CHK("digits", {5'h00, 7'(main), 4'h0, 4'(sub)}, digits)
        running = 1'b0;
        u_ppn_operator.press(KEY_SET);
        `CHK("digits", pval, digits)
        exp_val = pval;
        exp_val[3:0] = (pval[3:0] == 4'h9) ? 4'h0 : pval[3:0] + 4'h1;
        u_ppn_operator.press(KEY_UP);
        `CHK("digits", exp_val, digits)
        `CHK("blank", 5'h00, blank)
        exp_val[7:4] = (pval[7:4] == 4'h0) ? 4'h9 : pval[7:4] - 4'h1;
        u_ppn_operator.press(KEY_SHIFT);
        u_ppn_operator.press(KEY_DOWN);
        `CHK("digits", exp_val, digits)
        u_ppn_operator.press(KEY_SET);
        `CHK("commit", 1, n_commit)
        `CHK("cval", exp_val, cval)
        `CHK("show", 1'b0, showv)
        `CHK("digits", {5'h00, 7'(main), 4'h0, 4'(sub)}, digits)
        // with another selection method the shift key stays in main selection
        u_ppn_operator.press(KEY_SHIFT);
        `CHK("run", 1'b0, runs)
        msel = 4'h1;
        u_ppn_operator.press(KEY_SHIFT);
        u_ppn_operator.press(KEY_UP);
        `CHK("main", 7'h01, main_no)
        `CHK("sub", 4'h0, sub_no)
        `CHK("dp_sel", 1'b0, dp[DP_MAIN_SUB])
        finish_test();
    end
endmodule
